// ### rtl/pwmpac_pkg.sv
// Package with register map, field positions and shared types.
package pwmpac_pkg;

   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   // ==========================================================
   localparam logic [3:0] PRESCALE_IDX = 4'h3;
   localparam logic [3:0] ALIGN_IDX = 4'h4;
   localparam logic [3:0] CONTROL_IDX = 4'h5;
   localparam logic [5:0] PRESCALE_ADDR = {PRESCALE_IDX, 2'h0};
   localparam logic [5:0] ALIGN_ADDR = {ALIGN_IDX, 2'h0};
   localparam logic [5:0] CONTROL_ADDR = {CONTROL_IDX, 2'h0};
   localparam int ADDR_W = 6;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] PRESCALE_RST = 8'h00;
   localparam logic [7:0] ALIGN_RST = 8'h00;
   localparam logic [7:0] CONTROL_RST = 8'h00;

   // ==========================================================
   // Field positions and masks
   // ==========================================================
   localparam int CLKB_LSB = 4;
   localparam int CLKA_LSB = 0;
   localparam int JOIN67_BIT = 7;
   localparam int JOIN45_BIT = 6;
   localparam int JOIN23_BIT = 5;
   localparam int JOIN01_BIT = 4;
   localparam int WAIT_BIT = 3;
   localparam int FREEZE_BIT = 2;
   localparam logic [7:0] PRESCALE_MASK = 8'h77;
   localparam logic [7:0] ALIGN_MASK = 8'hff;
   localparam logic [7:0] CONTROL_MASK = 8'hfc;

   // ==========================================================
   // Prescaler and AXI constants
   // ==========================================================
   localparam int DIV_W = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic [2:0] clock_b_divider_select;
      logic [2:0] clock_a_divider_select;
   } pwmpac_prescale_s;

   typedef struct packed {
      logic [3:0] join_pairs;
      logic stop_in_wait;
      logic stop_in_freeze;
   } pwmpac_control_s;

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] polarity;
      logic [7:0] center;
      logic [7:0] scaled_clock_choice;
   } pwmpac_chan_s;

endpackage : pwmpac_pkg

// ### rtl/pwmpac_tap.sv
// Divider tap: one-cycle enable pulse at the selected bus-clock division.
module pwmpac_tap (
   // Counter state
   input wire logic [pwmpac_pkg::DIV_W-1:0] count,
   input wire logic run,
   // Selection
   input wire logic [2:0] sel,
   // Pulse out
   output logic tick
);

   logic [pwmpac_pkg::DIV_W:0] mask;

   // Division by 2**sel fires when the low sel counter bits are all zero.
   always_comb begin
      mask = (8'h01 << sel) - 8'h01;
      tick = run && ((count & mask[pwmpac_pkg::DIV_W-1:0]) == 7'h00);
   end

endmodule : pwmpac_tap

// ### rtl/pwmpac_top.sv
// Prescaler, alignment and pair-join control with AXI4-Lite registers.
// =============================================================
module pwmpac_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Operating modes
   input wire logic wait_mode,
   input wire logic freeze_mode,
   // Channel settings from the channel registers
   input wire pwmpac_pkg::pwmpac_chan_s chan_in,
   input wire logic clock_sa_tick,
   input wire logic clock_sb_tick,
   input wire logic [7:0] chan_wave,
   // Prescaled clocks to the channel logic
   output logic clock_a_tick,
   output logic clock_b_tick,
   output logic [7:0] chan_clock_tick,
   // Effective per-channel settings
   output pwmpac_pkg::pwmpac_chan_s chan_eff,
   output logic [3:0] join_pairs,
   // Output port
   output logic [7:0] modulator_output_port
);

   // ==========================================================
   // Registers
   // ==========================================================
   pwmpac_pkg::pwmpac_prescale_s prescale_q;
   logic [7:0] center_aligned_mode_bits_q;
   pwmpac_pkg::pwmpac_control_s control_q;
   logic [pwmpac_pkg::DIV_W-1:0] div_cnt_q;
   logic [7:0] port_q;

   // ==========================================================
   // AXI4-Lite slave
   // ==========================================================
   logic aw_held_q;
   logic w_held_q;
   logic [pwmpac_pkg::ADDR_W-1:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_go;
   logic aw_hit;

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign wr_go = aw_held_q && w_held_q && !bvalid_q;
   assign aw_hit = (awaddr_q == pwmpac_pkg::PRESCALE_ADDR) ||
                   (awaddr_q == pwmpac_pkg::ALIGN_ADDR) ||
                   (awaddr_q == pwmpac_pkg::CONTROL_ADDR);

   // Address and data are caught in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 6'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr[pwmpac_pkg::ADDR_W-1:0];
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata[7:0];
         wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= pwmpac_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= aw_hit ? pwmpac_pkg::RESP_OKAY :
                             pwmpac_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Register writes land at any time, frozen or not.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale_q <= 6'h00;
         center_aligned_mode_bits_q <= pwmpac_pkg::ALIGN_RST;
         control_q <= 6'h00;
      end else if (wr_go && wstrb0_q) begin
         unique case (awaddr_q)
            pwmpac_pkg::PRESCALE_ADDR: begin
               prescale_q <= {wdata_q[pwmpac_pkg::CLKB_LSB +: 3],
                              wdata_q[pwmpac_pkg::CLKA_LSB +: 3]};
            end
            pwmpac_pkg::ALIGN_ADDR: begin
               center_aligned_mode_bits_q <= wdata_q;
            end
            pwmpac_pkg::CONTROL_ADDR: begin
               control_q <= {wdata_q[pwmpac_pkg::JOIN67_BIT],
                             wdata_q[pwmpac_pkg::JOIN45_BIT],
                             wdata_q[pwmpac_pkg::JOIN23_BIT],
                             wdata_q[pwmpac_pkg::JOIN01_BIT],
                             wdata_q[pwmpac_pkg::WAIT_BIT],
                             wdata_q[pwmpac_pkg::FREEZE_BIT]};
            end
            default: begin
            end
         endcase
      end
   end

   // Read path; bits without a function read zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= pwmpac_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= pwmpac_pkg::RESP_OKAY;
         unique case (s_axi_araddr[pwmpac_pkg::ADDR_W-1:0])
            pwmpac_pkg::PRESCALE_ADDR: begin
               rdata_q <= {25'h0, prescale_q.clock_b_divider_select,
                           1'b0, prescale_q.clock_a_divider_select};
            end
            pwmpac_pkg::ALIGN_ADDR: begin
               rdata_q <= {24'h0, center_aligned_mode_bits_q};
            end
            pwmpac_pkg::CONTROL_ADDR: begin
               rdata_q <= {24'h0, control_q.join_pairs,
                           control_q.stop_in_wait,
                           control_q.stop_in_freeze, 2'h0};
            end
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= pwmpac_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Prescaler
   // ==========================================================
   logic pre_run;
   assign pre_run = !(wait_mode && control_q.stop_in_wait) &&
                    !(freeze_mode && control_q.stop_in_freeze) &&
                    (chan_in.enable != 8'h00);

   // Counter holds while gated and resumes from its held value when the gate opens.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_q <= 7'h00;
      end else if (pre_run) begin
         div_cnt_q <= div_cnt_q + 7'h01;
      end
   end

   pwmpac_tap u_tap_a (
      .count(div_cnt_q),
      .run(pre_run),
      .sel(prescale_q.clock_a_divider_select),
      .tick(clock_a_tick)
   );

   pwmpac_tap u_tap_b (
      .count(div_cnt_q),
      .run(pre_run),
      .sel(prescale_q.clock_b_divider_select),
      .tick(clock_b_tick)
   );

   // ==========================================================
   // Channel routing
   // ==========================================================
   logic [7:0] even_off;
   assign join_pairs = control_q.join_pairs;
   assign even_off = {1'b0, join_pairs[3], 1'b0, join_pairs[2],
                      1'b0, join_pairs[1], 1'b0, join_pairs[0]};

   always_comb begin
      chan_eff.enable = chan_in.enable;
      chan_eff.polarity = chan_in.polarity;
      chan_eff.center = center_aligned_mode_bits_q;
      chan_eff.scaled_clock_choice = chan_in.scaled_clock_choice;
      for (int p = 0; p < 4; p++) begin
         if (join_pairs[p]) begin
            chan_eff.enable[2*p] = chan_in.enable[2*p+1];
            chan_eff.polarity[2*p] = chan_in.polarity[2*p+1];
            chan_eff.center[2*p] = center_aligned_mode_bits_q[2*p+1];
            chan_eff.scaled_clock_choice[2*p] =
               chan_in.scaled_clock_choice[2*p+1];
         end
      end
   end

   always_comb begin
      for (int c = 0; c < 8; c++) begin
         if (c == 2 || c == 3 || c == 6 || c == 7) begin
            chan_clock_tick[c] = chan_eff.scaled_clock_choice[c] ?
                                 clock_sb_tick : clock_b_tick;
         end else begin
            chan_clock_tick[c] = chan_eff.scaled_clock_choice[c] ?
                                 clock_sa_tick : clock_a_tick;
         end
      end
   end

   // Joined pairs silence the even pin; odd pin carries the 16-bit wave.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_q <= 8'h00;
      end else begin
         port_q <= chan_wave & ~even_off;
      end
   end
   assign modulator_output_port = port_q;

   // ==========================================================
   // Assertions
   // ==========================================================
   property p_even_off;
      @(posedge aclk) disable iff (!aresetn)
      join_pairs[0] |=> !modulator_output_port[0];
   endproperty
   a_even_off: assert property (p_even_off)
      else $error("Joined even output not silenced.");

   property p_gate_freeze;
      @(posedge aclk) disable iff (!aresetn)
      (freeze_mode && control_q.stop_in_freeze) |->
         (!clock_a_tick && !clock_b_tick) ##1 $stable(div_cnt_q);
   endproperty
   a_gate_freeze: assert property (p_gate_freeze)
      else $error("Prescaler ran while frozen.");

   property p_gate_wait;
      @(posedge aclk) disable iff (!aresetn)
      (wait_mode && control_q.stop_in_wait) |-> !clock_a_tick && !clock_b_tick;
   endproperty
   a_gate_wait: assert property (p_gate_wait)
      else $error("Prescaler ran in wait mode.");

   property p_idle_stop;
      @(posedge aclk) disable iff (!aresetn)
      (chan_in.enable == 8'h00) |-> !clock_a_tick;
   endproperty
   a_idle_stop: assert property (p_idle_stop)
      else $error("Prescaler ran with no channel enabled.");

   property p_div_a128;
      @(posedge aclk) disable iff (!aresetn)
      (pre_run && prescale_q.clock_a_divider_select == 3'h7 &&
       clock_a_tick) |=> !clock_a_tick;
   endproperty
   a_div_a128: assert property (p_div_a128)
      else $error("Clock A pulsed twice in a row at divide 128.");

   property p_div_b1;
      @(posedge aclk) disable iff (!aresetn)
      (pre_run && prescale_q.clock_b_divider_select == 3'h0) |->
         clock_b_tick;
   endproperty
   a_div_b1: assert property (p_div_b1)
      else $error("Clock B missing at divide 1.");

   property p_join_cfg;
      @(posedge aclk) disable iff (!aresetn)
      join_pairs[3] |-> chan_eff.enable[6] == chan_in.enable[7] &&
         chan_eff.center[6] == center_aligned_mode_bits_q[7];
   endproperty
   a_join_cfg: assert property (p_join_cfg)
      else $error("Joined pair not governed by odd channel.");

   property p_ch2_src;
      @(posedge aclk) disable iff (!aresetn)
      !chan_eff.scaled_clock_choice[2] |->
         chan_clock_tick[2] == clock_b_tick;
   endproperty
   a_ch2_src: assert property (p_ch2_src)
      else $error("Channel 2 not on clock B.");

   property p_bresp_follows;
      @(posedge aclk) disable iff (!aresetn)
      wr_go |=> s_axi_bvalid;
   endproperty
   a_bresp_follows: assert property (p_bresp_follows)
      else $error("Write response missing.");

   c_join: cover property (@(posedge aclk) disable iff (!aresetn)
      join_pairs[1] && chan_wave[3]);
   c_freeze: cover property (@(posedge aclk) disable iff (!aresetn)
      freeze_mode && control_q.stop_in_freeze);
   c_div: cover property (@(posedge aclk) disable iff (!aresetn)
      prescale_q.clock_a_divider_select == 3'h7 && clock_a_tick);

endmodule : pwmpac_top

// ### test/pwm_prescale_align_concat_ctrl_tb.sv
// Self-checking bench for the prescaler, alignment and pair-join block.
module pwm_prescale_align_concat_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Signals
   // ==========================================================
   logic aclk, aresetn;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic wait_mode, freeze_mode, sa_tick, sb_tick, a_tick, b_tick;
   logic [7:0] chan_wave, ch_tick, port, exp_port, prev_wave;
   logic [3:0] joins;
   pwmpac_pkg::pwmpac_chan_s chan_in, chan_eff, exp_eff;
   logic [15:0] lfsr_q;
   logic [31:0] d, rd;
   logic [1:0] r;
   int err_total, n_compared, cnt_a, cnt_b, cnt_sa, cnt_sb, c, i, j, src;
   int cnt_ch[8];
   int ctl_m, align_m;

   pwmpac_top uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .wait_mode(wait_mode),
      .freeze_mode(freeze_mode), .chan_in(chan_in),
      .clock_sa_tick(sa_tick), .clock_sb_tick(sb_tick),
      .chan_wave(chan_wave), .clock_a_tick(a_tick), .clock_b_tick(b_tick),
      .chan_clock_tick(ch_tick), .chan_eff(chan_eff), .join_pairs(joins),
      .modulator_output_port(port));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^
         lfsr_q[10]};
      return lfsr_q;
   endfunction : rnd

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("BAD at %0t got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : check

   task automatic timed_out();
      $display("BAD at %0t got %h expected %h", $time, 32'h0, 32'h1);
      err_total++;
      conclude();
   endtask : timed_out

   // Write one word; each channel is released at the edge that takes it.
   task automatic axi_write(input logic [31:0] a, input logic [31:0] v,
      output logic [1:0] resp);
      int k;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            break;
         end
      end
      if (k == 100) begin
         timed_out();
      end
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [31:0] a, output logic [31:0] v,
      output logic [1:0] resp);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            break;
         end
      end
      if (k == 100) begin
         timed_out();
      end
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // Counts every tick output over n cycles while driving random scaled ticks.
   task automatic count_ticks(input int n);
      int k, m;
      cnt_a = 0; cnt_b = 0; cnt_sa = 0; cnt_sb = 0;
      for (m = 0; m < 8; m++) cnt_ch[m] = 0;
      for (k = 0; k < n; k++) begin
         @(posedge aclk);
         d = 32'(rnd());
         sa_tick <= d[0];
         sb_tick <= d[1];
         @(negedge aclk);
         cnt_a += int'(a_tick === 1'b1);
         cnt_b += int'(b_tick === 1'b1);
         cnt_sa += int'(sa_tick);
         cnt_sb += int'(sb_tick);
         for (m = 0; m < 8; m++) cnt_ch[m] += int'(ch_tick[m] === 1'b1);
      end
   endtask : count_ticks

   task automatic set_modes(input logic w, input logic f,
      input logic [7:0] en);
      @(posedge aclk);
      wait_mode <= w;
      freeze_mode <= f;
      chan_in.enable <= en;
   endtask : set_modes

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      aresetn = 1'b0; awaddr = '0; wdata = '0; wstrb = 4'h1; araddr = '0;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; wait_mode = 1'b0; freeze_mode = 1'b0; sa_tick = 1'b0;
      sb_tick = 1'b0; chan_wave = 8'h00; chan_in = '0; prev_wave = 8'h00;
      lfsr_q = 16'h000c; err_total = 0; n_compared = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, then random write and read-back with masking.
      axi_read(32'h0c, rd, r); check(rd, 32'h0);
      axi_read(32'h10, rd, r); check(rd, 32'h0);
      axi_read(32'h14, rd, r); check(rd, 32'h0);
      for (c = 0; c < 4; c++) begin
         d = {rnd(), rnd()};
         axi_write(32'h0c, d, r); check(32'(r), 32'h0);
         axi_read(32'h0c, rd, r); check(rd, d & 32'h77);
         axi_write(32'h10, d, r);
         axi_read(32'h10, rd, r); check(rd, d & 32'hff);
         axi_write(32'h14, d, r);
         axi_read(32'h14, rd, r); check(rd, d & 32'hfc);
      end
      axi_write(32'h18, 32'hff, r); check(32'(r), 32'h2);
      axi_read(32'h18, rd, r); check({rd[29:0], r}, 32'h2);
      axi_write(32'h14, 32'h0, r);
      // Every divider code on both clocks, changed with the prescaler running.
      set_modes(1'b0, 1'b0, 8'h01);
      for (c = 0; c < 8; c++) begin
         axi_write(32'h0c, 32'(((7 - c) << 4) | c), r);
         chan_in.scaled_clock_choice <= 8'(rnd());
         count_ticks(256);
         check(32'(cnt_a), 32'(256 >> c));
         check(32'(cnt_b), 32'(256 >> (7 - c)));
         for (i = 0; i < 8; i++) begin
            if (i == 2 || i == 3 || i == 6 || i == 7) begin
               j = chan_in.scaled_clock_choice[i] ? cnt_sb : cnt_b;
            end else begin
               j = chan_in.scaled_clock_choice[i] ? cnt_sa : cnt_a;
            end
            check(32'(cnt_ch[i]), 32'(j));
         end
      end
      // Wait and freeze gating in all combinations, registers still reached.
      axi_write(32'h0c, 32'h11, r);
      for (c = 0; c < 16; c++) begin
         set_modes(c[0], c[1], 8'h80);
         ctl_m = (c[2] << 3) | (c[3] << 2);
         axi_write(32'h14, 32'(ctl_m), r);
         axi_read(32'h14, rd, r); check(rd, 32'(ctl_m));
         count_ticks(64);
         j = ((c[0] && c[2]) || (c[1] && c[3])) ? 0 : 32;
         check(32'(cnt_a), 32'(j));
         check(32'(cnt_b), 32'(j));
      end
      set_modes(1'b0, 1'b0, 8'h00);
      count_ticks(64);
      check(32'(cnt_a + cnt_b), 32'h0);
      // Every join pattern with random settings and waveforms.
      for (c = 0; c < 16; c++) begin
         ctl_m = c << 4;
         align_m = 32'(8'(rnd()));
         @(posedge aclk);
         chan_in.enable <= 8'h00;
         axi_write(32'h14, 32'(ctl_m), r);
         axi_write(32'h10, 32'(align_m), r);
         chan_in <= {rnd(), rnd()};
         @(negedge aclk);
         check(32'(joins), 32'(c));
         for (i = 0; i < 8; i++) begin
            src = c[i / 2] ? (i | 1) : i;
            exp_eff.enable[i] = chan_in.enable[src];
            exp_eff.polarity[i] = chan_in.polarity[src];
            exp_eff.center[i] = align_m[src];
            exp_eff.scaled_clock_choice[i] = chan_in.scaled_clock_choice[src];
         end
         check(chan_eff, exp_eff);
         exp_port = ~{1'b0, c[3], 1'b0, c[2], 1'b0, c[1], 1'b0, c[0]};
         for (j = 0; j < 5; j++) begin
            @(posedge aclk);
            chan_wave <= 8'(rnd());
            @(negedge aclk);
            if (j > 0) begin
               check(32'(port), 32'(prev_wave & exp_port));
            end
            prev_wave = chan_wave;
         end
      end
      conclude();
   end

endmodule : pwm_prescale_align_concat_ctrl_tb
